// *** fasr_pkg.sv ***
// Package of constants and types for the fast alarm status register bank.
package fasr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************

  // Byte addresses of the two status registers on the device memory.
  localparam logic [7:0] FASR_TX_ADDR = 8'h72;
  localparam logic [7:0] FASR_RX_ADDR = 8'h73;

  // Power-on value of both registers.
  localparam logic [7:0] FASR_RESET_VAL = 8'h00;

  // Field positions in the transmit-side register.
  localparam int FASR_TX_PWR_LOW_BIT = 0;
  localparam int FASR_TX_PWR_HIGH_BIT = 1;
  localparam int FASR_HIGH_BIAS_BIT = 3;

  // Field positions in the receive-side register.
  localparam int FASR_BIAS_CEIL_BIT = 3;
  localparam int FASR_RX_LVL_LOW_BIT = 6;
  localparam int FASR_RX_LVL_HIGH_BIT = 7;

  // Number of synchroniser stages on comparator inputs.
  localparam int FASR_SYNC_STAGES = 2;

  // ****************************************************************
  // Types
  // ****************************************************************

  // Raw fast comparator outcomes, one bit per tracked condition.
  typedef struct packed {
    logic highBias;
    logic txPwrHigh;
    logic txPwrLow;
    logic rxLvlHigh;
    logic rxLvlLow;
    logic biasCeil;
    logic txDisable;
  } fasr_cmp_t;

  // Full state of the register bank.
  typedef struct packed {
    logic [7:0] txStat;
    logic [7:0] rxStat;
    logic [7:0] rdData;
    logic       txFaultSum;
  } fasr_state_t;

endpackage

// *** fasr_sync_if.sv ***
// Interface carrying synchronised comparator outcomes between modules.
`timescale 1ns/100ps
`default_nettype none
interface fasr_sync_if;
  import fasr_pkg::*;

  // Comparator outcomes after the two-stage synchroniser.
  fasr_cmp_t cmp;

  modport src (output cmp);
  modport dst (input cmp);
endinterface
`default_nettype wire

// *** fasr_sync.sv ***
// Two-flop synchroniser for the asynchronous comparator outputs.
`timescale 1ns/100ps
`default_nettype none
module fasr_sync
  import fasr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire fasr_cmp_t rawCmp,
  fasr_sync_if.src syncOut
);

  // ****************************************************************
  // Synchroniser state
  // ****************************************************************

  // First and second stages; the first is read only by the second.
  typedef struct packed {
    fasr_cmp_t stage1;
    fasr_cmp_t stage2;
  } fasr_sync_state_t;

  fasr_sync_state_t sync_reg;
  fasr_sync_state_t sync_next;

  // Shift the comparator levels one stage per clock.
  always_comb begin
    sync_next = sync_reg;
    sync_next.stage1 = rawCmp;
    sync_next.stage2 = sync_reg.stage1;
  end

  // Both stages clear at reset so no alarm is seen before power-on ends.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign syncOut.cmp = sync_reg.stage2;

endmodule
`default_nettype wire

// *** fasr_regs.sv ***
// Fast alarm status register bank: two read-only, volatile registers.
//
// Operation
// - Transmit register volatile, zero at reset, read-only.
// - Receive register volatile, zero at reset, read-only.
// - High-bias bit tracks comparator, disable clears.
// - Tx-power-high bit tracks comparator, disable clears.
// - Tx-power-low bit tracks comparator, disable clears.
// - Rx-level-high bit tracks, disable leaves unchanged.
// - Rx-level-low bit tracks, disable leaves unchanged.
// - Bias ceiling bit tracks request, disable clears.
// - Fault summary includes four transmit alarms unmasked.
`timescale 1ns/100ps
`default_nettype none
module fasr_regs
  import fasr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic highBiasCmp,
  input wire logic txPowerHighCmp,
  input wire logic txPowerLowCmp,
  input wire logic rxLevelHighCmp,
  input wire logic rxLevelLowCmp,
  input wire logic biasCeilingCmp,
  input wire logic txDisable,
  input wire logic [7:0] rdAddr,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic [7:0] fastAlarmStatusTx,
  output logic [7:0] fastAlarmStatusRx,
  output logic txFaultInterruptSummary
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  // Comparators and the disable pin are analog-side, hence asynchronous.
  fasr_cmp_t rawCmp;
  fasr_sync_if syncBus ();

  // Gather the raw levels into one bundle for the synchroniser.
  always_comb begin
    rawCmp.highBias = highBiasCmp;
    rawCmp.txPwrHigh = txPowerHighCmp;
    rawCmp.txPwrLow = txPowerLowCmp;
    rawCmp.rxLvlHigh = rxLevelHighCmp;
    rawCmp.rxLvlLow = rxLevelLowCmp;
    rawCmp.biasCeil = biasCeilingCmp;
    rawCmp.txDisable = txDisable;
  end

  // Two flops sit between every comparator and disable pin and the logic below; the extra
  // latency is harmless because the flags are levels, not pulses.
  fasr_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .rawCmp(rawCmp),
    .syncOut(syncBus.src)
  );

  // ****************************************************************
  // Register state
  // ****************************************************************

  // Registered state of the bank and its next value.
  fasr_state_t st_reg;
  fasr_state_t st_next;
  // Synchronised comparator levels, the only view the logic has of them.
  fasr_cmp_t c;

  // Taken straight from the interface instance as it leaves the second
  // flop; nothing here reads the first stage.
  assign c = syncBus.cmp;

  // Host writes (wrEn, wrData) are accepted on the bus but have no path
  // into the state; both registers are read-only to the host.
  always_comb begin
    st_next = st_reg;
    // Everything not assigned below stays zero, so reserved bits read 0.
    st_next.txStat = FASR_RESET_VAL;
    st_next.rxStat = FASR_RESET_VAL;
    if (c.txDisable) begin
      // Transmit-side alarms are forced low while disable is asserted.
      st_next.txStat[FASR_HIGH_BIAS_BIT] = 1'b0;
      st_next.txStat[FASR_TX_PWR_HIGH_BIT] = 1'b0;
      st_next.txStat[FASR_TX_PWR_LOW_BIT] = 1'b0;
      st_next.rxStat[FASR_BIAS_CEIL_BIT] = 1'b0;
    end else begin
      // Each bit follows the latest fast comparison.
      st_next.txStat[FASR_HIGH_BIAS_BIT] = c.highBias;
      st_next.txStat[FASR_TX_PWR_HIGH_BIT] = c.txPwrHigh;
      st_next.txStat[FASR_TX_PWR_LOW_BIT] = c.txPwrLow;
      st_next.rxStat[FASR_BIAS_CEIL_BIT] = c.biasCeil;
    end
    // Receive-side level alarms ignore the disable event.
    st_next.rxStat[FASR_RX_LVL_HIGH_BIT] = c.rxLvlHigh;
    st_next.rxStat[FASR_RX_LVL_LOW_BIT] = c.rxLvlLow;
    // The four transmit alarms feed the summary with no mask in the way.
    st_next.txFaultSum = st_next.txStat[FASR_HIGH_BIAS_BIT] |
                         st_next.txStat[FASR_TX_PWR_HIGH_BIT] |
                         st_next.txStat[FASR_TX_PWR_LOW_BIT] |
                         st_next.rxStat[FASR_BIAS_CEIL_BIT];
    // Registered read port; unmapped addresses read zero.
    unique case (rdAddr)
      FASR_TX_ADDR: begin
        st_next.rdData = st_next.txStat;
      end
      FASR_RX_ADDR: begin
        st_next.rdData = st_next.rxStat;
      end
      default: begin
        st_next.rdData = 8'h00;
      end
    endcase
  end

  // Both registers are volatile and return to zero on reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.txStat <= FASR_RESET_VAL;
      st_reg.rxStat <= FASR_RESET_VAL;
      st_reg.rdData <= 8'h00;
      st_reg.txFaultSum <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a flop of the state; no logic sits after the register,
  // so the pins never glitch when a comparator moves.
  assign rdData = st_reg.rdData;
  assign fastAlarmStatusTx = st_reg.txStat;
  assign fastAlarmStatusRx = st_reg.rxStat;
  assign txFaultInterruptSummary = st_reg.txFaultSum;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // All checks run in the one clock domain and are muted during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_TX_WRITE_IGNORED: assert property (
    wrEn && !c.txDisable && $stable(c) |=> $stable(st_reg.txStat))
    else $error("Write changed transmit status.");
  AST_RX_WRITE_IGNORED: assert property (
    wrEn && $stable(c) |=> $stable(st_reg.rxStat))
    else $error("Write changed receive status.");
  AST_HBIAS_TRACK: assert property (
    fastAlarmStatusTx[FASR_HIGH_BIAS_BIT] == ($past(c.highBias) &&
      !$past(c.txDisable)))
    else $error("High bias bit wrong.");
  AST_TXPH_TRACK: assert property (
    c.txDisable |=> !fastAlarmStatusTx[FASR_TX_PWR_HIGH_BIT])
    else $error("Tx power high not cleared.");
  AST_TXPL_TRACK: assert property (
    c.txPwrLow && !c.txDisable |=> fastAlarmStatusTx[FASR_TX_PWR_LOW_BIT])
    else $error("Tx power low not set.");
  AST_RXH_KEEP: assert property (
    c.txDisable && c.rxLvlHigh |=> fastAlarmStatusRx[FASR_RX_LVL_HIGH_BIT])
    else $error("Rx level high lost on disable.");
  AST_RXL_KEEP: assert property (
    c.txDisable && c.rxLvlLow |=> fastAlarmStatusRx[FASR_RX_LVL_LOW_BIT])
    else $error("Rx level low lost on disable.");
  AST_BCEIL_TRACK: assert property (
    c.biasCeil ##1 c.txDisable |=> !fastAlarmStatusRx[FASR_BIAS_CEIL_BIT])
    else $error("Bias ceiling not cleared.");
  AST_SUMMARY: assert property (
    txFaultInterruptSummary == (|(fastAlarmStatusTx & 8'h0b) ||
      fastAlarmStatusRx[FASR_BIAS_CEIL_BIT]))
    else $error("Fault summary mismatch.");
  AST_RESERVED: assert property (
    (fastAlarmStatusTx & 8'hf4) == 8'h00 &&
    (fastAlarmStatusRx & 8'h37) == 8'h00)
    else $error("Reserved bit set.");
  // A read returns the value the register takes on the same edge.
  AST_RD_TX: assert property (
    rdAddr == FASR_TX_ADDR |=> rdData == fastAlarmStatusTx)
    else $error("Transmit status read back wrong.");
  AST_RD_RX: assert property (
    rdAddr == FASR_RX_ADDR |=> rdData == fastAlarmStatusRx)
    else $error("Receive status read back wrong.");
  // Unmapped addresses must not leak either register onto the read port.
  AST_RD_OTHER: assert property (
    rdAddr != FASR_TX_ADDR && rdAddr != FASR_RX_ADDR |=> rdData == 8'h00)
    else $error("Unmapped address read non-zero.");
  // The flags are live levels: tx power high and both rx levels are checked both ways;
  // tx power low and bias ceiling are checked only for set and for clear on disable.
  AST_TXPH_SET: assert property (
    c.txPwrHigh && !c.txDisable |=> fastAlarmStatusTx[FASR_TX_PWR_HIGH_BIT])
    else $error("Tx power high not set.");
  AST_TXPH_OFF: assert property (
    !c.txPwrHigh |=> !fastAlarmStatusTx[FASR_TX_PWR_HIGH_BIT])
    else $error("Tx power high stuck.");
  AST_TXPL_CLR: assert property (
    c.txDisable |=> !fastAlarmStatusTx[FASR_TX_PWR_LOW_BIT])
    else $error("Tx power low not cleared.");
  AST_RXH_TRACK: assert property (
    fastAlarmStatusRx[FASR_RX_LVL_HIGH_BIT] == $past(c.rxLvlHigh))
    else $error("Rx level high does not track.");
  AST_RXL_TRACK: assert property (
    fastAlarmStatusRx[FASR_RX_LVL_LOW_BIT] == $past(c.rxLvlLow))
    else $error("Rx level low does not track.");
  AST_BCEIL_SET: assert property (
    c.biasCeil && !c.txDisable |=> fastAlarmStatusRx[FASR_BIAS_CEIL_BIT])
    else $error("Bias ceiling not set.");

  // Main scenarios: an alarm reaching the summary, a disable while alarms
  // stand, and a non-zero read of the receive register.
  COV_TX_ALARM: cover property (c.highBias ##1 txFaultInterruptSummary);
  COV_DISABLE: cover property (c.txPwrHigh ##1 c.txDisable);
  COV_RX_HELD: cover property (c.rxLvlLow && c.txDisable);
  COV_READ_RX: cover property (rdAddr == FASR_RX_ADDR ##1 rdData != 8'h00);
  COV_BCEIL_CLR: cover property (c.biasCeil && c.txDisable);

endmodule
`default_nettype wire

// *** fasr_host_model.sv ***
// Host model that reads and writes the status bank over its register port.
`timescale 1ns/100ps
`default_nettype none
module fasr_host_model (
  input wire logic clk,
  input wire logic [7:0] rdData,
  output var logic [7:0] rdAddr,
  output var logic wrEn,
  output var logic [7:0] wrData
);
  // Idle values at time zero, so the bank never samples unknowns.
  initial begin
    rdAddr = 8'h00;
    wrEn = 1'b0;
    wrData = 8'h00;
  end

  // Address goes out after an edge; data is taken once the next edge lands.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rdAddr <= a;
    @(posedge clk);
    #1;
    d = rdData;
  endtask

  // A write is offered for one cycle; the bank must ignore it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rdAddr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    wrData <= ~d;
  endtask
endmodule
`default_nettype wire

// *** fasr_regs_tb.sv ***
// Self-checking testbench for the fast alarm status register bank.
`timescale 1ns/100ps
`default_nettype none
module fasr_regs_tb;
  import fasr_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] cmp = 6'h00; // Bias, txHigh, txLow, rxHigh, rxLow, ceiling.
  logic txDis = 1'b0;
  logic [7:0] rdAddr, wrData, rdData, statTx, statRx, d;
  logic wrEn, sum;
  int errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  fasr_regs dut_u (.clk(clk), .rstn(rstn), .highBiasCmp(cmp[5]),
    .txPowerHighCmp(cmp[4]), .txPowerLowCmp(cmp[3]),
    .rxLevelHighCmp(cmp[2]), .rxLevelLowCmp(cmp[1]),
    .biasCeilingCmp(cmp[0]), .txDisable(txDis), .rdAddr(rdAddr),
    .wrEn(wrEn), .wrData(wrData), .rdData(rdData),
    .fastAlarmStatusTx(statTx), .fastAlarmStatusRx(statRx),
    .txFaultInterruptSummary(sum));
  fasr_host_model host_u (.clk(clk), .rdData(rdData), .rdAddr(rdAddr),
    .wrEn(wrEn), .wrData(wrData));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Compares one value and reports a mismatch at once.
  task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads both registers and checks them, the direct outputs and summary.
  task automatic look(input logic [7:0] tx, input logic [7:0] rx);
    host_u.rd(FASR_TX_ADDR, d);
    expect8(d, tx);
    host_u.rd(FASR_RX_ADDR, d);
    expect8(d, rx);
    expect8(statTx, tx);
    expect8(statRx, rx);
    expect8({7'h00, sum}, {7'h00, tx[3] | tx[1] | tx[0] | rx[3]});
  endtask
  // Drives the comparators, waits past the three-edge latency, checks.
  task automatic one(input logic [5:0] c, input logic dis,
                     input logic [7:0] tx, input logic [7:0] rx);
    @(posedge clk);
    cmp <= c;
    txDis <= dis;
    repeat (4) @(posedge clk);
    look(tx, rx);
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  // Watchdog: the tests need about 140 cycles; this allows far more.
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("MISMATCH at %0t: run did not finish", $time);
    end_sim();
  end
  // Main sequence of register accesses with expected values.
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    look(8'h00, 8'h00);
    host_u.wr(FASR_TX_ADDR, 8'hff);
    host_u.wr(FASR_RX_ADDR, 8'hff);
    look(8'h00, 8'h00);
    one(6'h20, 1'b0, 8'h08, 8'h00);
    one(6'h10, 1'b0, 8'h02, 8'h00);
    one(6'h08, 1'b0, 8'h01, 8'h00);
    one(6'h04, 1'b0, 8'h00, 8'h80);
    one(6'h02, 1'b0, 8'h00, 8'h40);
    one(6'h01, 1'b0, 8'h00, 8'h08);
    one(6'h3f, 1'b0, 8'h0b, 8'hc8);
    host_u.wr(FASR_RX_ADDR, 8'h00);
    look(8'h0b, 8'hc8);
    host_u.rd(8'h74, d);
    expect8(d, 8'h00);
    one(6'h3f, 1'b1, 8'h00, 8'hc0);
    one(6'h06, 1'b1, 8'h00, 8'hc0);
    one(6'h3f, 1'b0, 8'h0b, 8'hc8);
    one(6'h00, 1'b0, 8'h00, 8'h00);
    // A reset in mid-run must clear live alarms, so raise them first.
    one(6'h3f, 1'b0, 8'h0b, 8'hc8);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    expect8(statTx, 8'h00);
    expect8(statRx, 8'h00);
    expect8({7'h00, sum}, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    // The synchroniser restarts empty: two edges pass before any flag.
    repeat (2) @(posedge clk);
    #1;
    expect8(statTx, 8'h00);
    @(posedge clk);
    #1;
    expect8(statTx, 8'h0b);
    expect8(statRx, 8'hc8);
    end_sim();
  end
endmodule
`default_nettype wire
